/* inc/sltc_pkg.sv */
package sltc_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] SLTC_TEST_SCRATCH_OFS = 8'h6c;
    localparam logic [7:0] SLTC_TIMER_CTRL_OFS = 8'h70;
    localparam logic [7:0] SLTC_FWD_POLICY_OFS = 8'h74;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] SLTC_TEST_SCRATCH_RST = 32'h0400_0800;
    localparam logic [11:0] SLTC_REPLAY_USER_RST = 12'h000;
    localparam logic [13:0] SLTC_ACK_USER_RST = 14'h0000;
    localparam logic SLTC_VGA_DECODE_RST = 1'b1;
    localparam logic [1:0] SLTC_CT_THRESH_RST = 2'h1;
    // ------------------------------------------------------------
    // field positions at 0x70 and 0x74
    // ------------------------------------------------------------
    localparam int SLTC_REPLAY_VAL_LSB = 0;
    localparam int SLTC_REPLAY_EN_BIT = 12;
    localparam int SLTC_ACK_VAL_LSB = 16;
    localparam int SLTC_ACK_EN_BIT = 30;
    localparam int SLTC_VGA_BIT = 31;
    localparam int SLTC_STORE_FWD_BIT = 0;
    localparam int SLTC_CT_THRESH_LSB = 1;
    localparam int SLTC_ARB_STICKY_BIT = 3;
    localparam int SLTC_CREDIT_ALL_BIT = 4;
    // ------------------------------------------------------------
    // credit types
    // ------------------------------------------------------------
    localparam int SLTC_NUM_CREDIT_TYPES = 3;
endpackage

/* verilog/sltc_config.sv */
// Notes on behaviour
// - 12-bit read-write user replay timer in bits 11:0, reset zero.
// - replay enable bit 12 selects the user replay timeout; enable resets zero.
// - 14-bit read-write user acknowledge latency field, reset zero.
// - acknowledge latency enable selects the user latency value; enable resets zero.
// - smbus or eeprom autoload may replace the reset defaults of fields.
// - read-only vga range decode bit reads one.
// - bit 0 set means store-and-forward, clear means cut-through; reset clear.
// - bits 2:1 pick cut-through start: midpoint minus 0..3 cycles; reset 01b.
// - bit 3 set: arbiter stays on last granted port while it requests.
// - bit 3 clear: arbiter moves to requesting port with enough credit.
// - bit 4 set: each credit release covers all credit types together.
// - bit 4 clear: credits released one type per update.
// - 32-bit read-write test register, reset 0400_0800h, steers nothing.
`timescale 1ns/10ps
module sltc_config
#(
    parameter int NUM_PORTS = 4,
    parameter logic [11:0] REPLAY_DEFAULT = 12'h100,
    parameter logic [13:0] ACK_DEFAULT = 14'h0040
) (
    input wire logic sys_clk,
    input wire logic rstn,
    // configuration access
    input wire logic cfg_req,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    // default override from smbus or eeprom autoload
    input wire logic ld_valid,
    input wire logic [7:0] ld_addr,
    input wire logic [31:0] ld_data,
    // packet framing of the forwarding path
    input wire logic pkt_start,
    input wire logic pkt_end,
    // port arbitration
    input wire logic arb_next,
    input wire logic [NUM_PORTS-1:0] arb_req,
    input wire logic [NUM_PORTS-1:0] arb_credit_ok,
    output logic [$clog2(NUM_PORTS)-1:0] arb_grant,
    output logic arb_grant_valid,
    // credit release toward the link partner
    input wire logic cred_tick,
    input wire logic [sltc_pkg::SLTC_NUM_CREDIT_TYPES-1:0] cred_pend,
    output logic [sltc_pkg::SLTC_NUM_CREDIT_TYPES-1:0] cred_release,
    // effective settings
    output logic [11:0] replay_timeout,
    output logic [13:0] ack_latency,
    output logic store_forward,
    output logic [1:0] ct_ahead_cycles,
    output logic vga_decode_en
);
    import sltc_pkg::*;

    localparam int PW = $clog2(NUM_PORTS);

    // ------------------------------------------------------------
    // software-visible registers
    // ------------------------------------------------------------
    logic [31:0] scratch_reg;
    logic [11:0] replay_user_reg;
    logic replay_en_reg;
    logic [13:0] ack_user_reg;
    logic ack_en_reg;
    logic store_fwd_reg;
    logic [1:0] ct_thresh_reg;
    logic arb_sticky_reg;
    logic credit_all_reg;
    logic [31:0] timer_word;
    logic [31:0] policy_word;
    logic cfg_we;
    logic [3:0] be;
    logic [7:0] waddr;
    logic [31:0] wdata;

    // an autoload write is a full word; a config write wins if both collide
    assign cfg_we = cfg_req & cfg_wr;
    assign be = cfg_we ? cfg_be : 4'hf;
    assign waddr = cfg_we ? cfg_addr : ld_addr;
    assign wdata = cfg_we ? cfg_wdata : ld_data;

    // test word, no other logic reads it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            scratch_reg <= SLTC_TEST_SCRATCH_RST;
        end else if ((cfg_we | ld_valid) && waddr == SLTC_TEST_SCRATCH_OFS) begin
            for (int b = 0; b < 4; b++) begin
                if (be[b]) begin
                    scratch_reg[b*8 +: 8] <= wdata[b*8 +: 8];
                end
            end
        end
    end

    // timer word: replay field in the low half, ack latency in the high half
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            replay_user_reg <= SLTC_REPLAY_USER_RST;
            replay_en_reg <= 1'b0;
            ack_user_reg <= SLTC_ACK_USER_RST;
            ack_en_reg <= 1'b0;
        end else if ((cfg_we | ld_valid) && waddr == SLTC_TIMER_CTRL_OFS) begin
            if (be[0]) begin
                replay_user_reg[7:0] <= wdata[7:0];
            end
            if (be[1]) begin
                replay_user_reg[11:8] <= wdata[11:8];
                replay_en_reg <= wdata[SLTC_REPLAY_EN_BIT];
            end
            if (be[2]) begin
                ack_user_reg[7:0] <= wdata[SLTC_ACK_VAL_LSB +: 8];
            end
            if (be[3]) begin
                ack_user_reg[13:8] <= wdata[SLTC_ACK_VAL_LSB+8 +: 6];
                ack_en_reg <= wdata[SLTC_ACK_EN_BIT];
            end
        end
    end

    // forwarding policy word, only the low byte carries fields
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            store_fwd_reg <= 1'b0;
            ct_thresh_reg <= SLTC_CT_THRESH_RST;
            arb_sticky_reg <= 1'b0;
            credit_all_reg <= 1'b0;
        end else if ((cfg_we | ld_valid) && waddr == SLTC_FWD_POLICY_OFS && be[0]) begin
            store_fwd_reg <= wdata[SLTC_STORE_FWD_BIT];
            ct_thresh_reg <= wdata[SLTC_CT_THRESH_LSB +: 2];
            arb_sticky_reg <= wdata[SLTC_ARB_STICKY_BIT];
            credit_all_reg <= wdata[SLTC_CREDIT_ALL_BIT];
        end
    end

    // ------------------------------------------------------------
    // read path, one cycle answer, unmapped reads zero
    // ------------------------------------------------------------
    assign timer_word = {SLTC_VGA_DECODE_RST, ack_en_reg, ack_user_reg, 3'h0,
                         replay_en_reg, replay_user_reg};
    assign policy_word = {27'h0, credit_all_reg, arb_sticky_reg, ct_thresh_reg,
                          store_fwd_reg};

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_rdata <= 32'h0;
            cfg_ack <= 1'b0;
        end else begin
            cfg_ack <= cfg_req;
            if (cfg_req && !cfg_wr) begin
                unique case (cfg_addr)
                    SLTC_TEST_SCRATCH_OFS: cfg_rdata <= scratch_reg;
                    SLTC_TIMER_CTRL_OFS: cfg_rdata <= timer_word;
                    SLTC_FWD_POLICY_OFS: cfg_rdata <= policy_word;
                    default: cfg_rdata <= 32'h0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // link timer selection
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            replay_timeout <= REPLAY_DEFAULT;
            ack_latency <= ACK_DEFAULT;
            vga_decode_en <= SLTC_VGA_DECODE_RST;
        end else begin
            replay_timeout <= replay_en_reg ? replay_user_reg : REPLAY_DEFAULT;
            ack_latency <= ack_en_reg ? ack_user_reg : ACK_DEFAULT;
            vga_decode_en <= SLTC_VGA_DECODE_RST;
        end
    end

    // ------------------------------------------------------------
    // packet-boundary capture of forwarding settings
    // ------------------------------------------------------------
    logic in_pkt_reg;
    logic arb_sticky_act;
    logic boundary;

    // a change mid-packet would corrupt a cut-through packet already in flight
    assign boundary = pkt_start & ~in_pkt_reg;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            in_pkt_reg <= 1'b0;
        end else if (pkt_start) begin
            in_pkt_reg <= ~pkt_end;
        end else if (pkt_end) begin
            in_pkt_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            store_forward <= 1'b0;
            ct_ahead_cycles <= SLTC_CT_THRESH_RST;
            arb_sticky_act <= 1'b0;
        end else if (boundary) begin
            store_forward <= store_fwd_reg;
            ct_ahead_cycles <= ct_thresh_reg;
            arb_sticky_act <= arb_sticky_reg;
        end
    end

    // ------------------------------------------------------------
    // round-robin port arbiter
    // ------------------------------------------------------------
    logic [PW-1:0] pick;
    logic pick_ok;
    logic [PW-1:0] idx;

    // search from the port after the last grant so every port gets a turn
    always_comb begin
        pick = arb_grant;
        pick_ok = 1'b0;
        idx = '0;
        if (arb_sticky_act && arb_grant_valid && arb_req[arb_grant]) begin
            pick_ok = 1'b1;
        end else begin
            for (int k = NUM_PORTS; k >= 1; k--) begin
                idx = PW'((32'(arb_grant) + k) % NUM_PORTS);
                if (arb_req[idx] && arb_credit_ok[idx]) begin
                    pick = idx;
                    pick_ok = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            arb_grant <= '0;
            arb_grant_valid <= 1'b0;
        end else if (arb_next) begin
            arb_grant <= pick;
            arb_grant_valid <= pick_ok;
        end
    end

    // ------------------------------------------------------------
    // credit release scheduling
    // ------------------------------------------------------------
    logic [1:0] cred_ptr;

    // type mode walks the types so none starves behind a busy one
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cred_release <= '0;
            cred_ptr <= 2'h0;
        end else begin
            cred_release <= '0;
            if (cred_tick) begin
                if (credit_all_reg) begin
                    cred_release <= cred_pend;
                end else begin
                    cred_release[cred_ptr] <= cred_pend[cred_ptr];
                    cred_ptr <= (cred_ptr == 2'(SLTC_NUM_CREDIT_TYPES - 1)) ?
                                2'h0 : cred_ptr + 2'h1;
                end
            end
        end
    end
endmodule

/* verification/sltc_config_checker.sv */
`timescale 1ns/10ps
// ----------------------------------------
// configuration block checker
// ----------------------------------------
module sltc_config_checker
#(parameter int NUM_PORTS = 4) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic cfg_req,
    input wire logic cfg_wr,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    input wire logic pkt_start,
    input wire logic arb_next,
    input wire logic [NUM_PORTS-1:0] arb_req,
    input wire logic [$clog2(NUM_PORTS)-1:0] arb_grant,
    input wire logic arb_grant_valid,
    input wire logic cred_tick,
    input wire logic [sltc_pkg::SLTC_NUM_CREDIT_TYPES-1:0] cred_pend,
    input wire logic [sltc_pkg::SLTC_NUM_CREDIT_TYPES-1:0] cred_release,
    input wire logic store_forward,
    input wire logic [1:0] ct_ahead_cycles,
    input wire logic vga_decode_en
);
    import sltc_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // a read, then a quiet cycle: the captured word must hold
    sequence s_rd_quiet;
        cfg_req && !cfg_wr ##1 !cfg_req;
    endsequence
    property p_ack; cfg_req |=> cfg_ack; endproperty
    property p_no_ack; !cfg_req |=> !cfg_ack; endproperty
    property p_rd_hold; s_rd_quiet |=> $stable(cfg_rdata); endproperty
    property p_vga; vga_decode_en; endproperty
    property p_pkt; !pkt_start |=> $stable(store_forward) && $stable(ct_ahead_cycles); endproperty
    property p_cred; cred_tick |=> (cred_release & ~$past(cred_pend)) == '0; endproperty
    property p_cred_idle; !cred_tick |=> cred_release == '0; endproperty
    property p_grant_req;
        arb_next |=> !arb_grant_valid || ((($past(arb_req) >> arb_grant) & 1) != 0);
    endproperty
    property p_grant_hold; !arb_next |=> $stable(arb_grant); endproperty
    a_ack: assert property (p_ack) else $error("access without ack");
    a_no_ack: assert property (p_no_ack) else $error("ack without access");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_vga: assert property (p_vga) else $error("vga decode low");
    a_pkt: assert property (p_pkt) else $error("mode changed mid packet");
    a_cred: assert property (p_cred) else $error("credit released unpended");
    a_cred_idle: assert property (p_cred_idle) else $error("credit without tick");
    a_grant_req: assert property (p_grant_req) else $error("grant to idle port");
    a_grant_hold: assert property (p_grant_hold) else $error("grant moved idle");
endmodule

/* verification/sltc_pkt_src.sv */
`timescale 1ns/10ps
// ----------------------------------------
// packet framer of the forwarding path
// ----------------------------------------
module sltc_pkt_src #(parameter int LEN = 8) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic go,
    output logic pkt_start,
    output logic pkt_end
);
    int cnt;
    // frames of LEN cycles; a go while a frame is open is dropped, never nested
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 0;
            pkt_start <= 1'b0;
            pkt_end <= 1'b0;
        end else begin
            pkt_start <= go && cnt == 0;
            pkt_end <= cnt == 2;
            cnt <= (go && cnt == 0) ? LEN : (cnt == 0 ? 0 : cnt - 1);
        end
    end
endmodule

/* verification/sltc_config_tb.sv */
`timescale 1ns/10ps
module sltc_config_tb;
    import sltc_pkg::*;
    localparam logic [11:0] RDEF = 12'h100;
    localparam logic [13:0] ADEF = 14'h0040;
    logic sys_clk, rstn, cfg_req, cfg_wr, ld_valid, arb_next, cred_tick, go;
    logic cfg_ack, pkt_start, pkt_end, arb_grant_valid, store_forward, vga_decode_en;
    logic [7:0] cfg_addr, ld_addr;
    logic [3:0] cfg_be, arb_req, arb_credit_ok;
    logic [31:0] cfg_wdata, ld_data, cfg_rdata, r, prev;
    logic [2:0] cred_pend, cred_release;
    logic [1:0] arb_grant, ct_ahead_cycles;
    logic [11:0] replay_timeout;
    logic [13:0] ack_latency;
    int fails = 0;
    int cmp_count = 0;
    sltc_config #(.NUM_PORTS(4), .REPLAY_DEFAULT(RDEF), .ACK_DEFAULT(ADEF)) uut (
        .sys_clk(sys_clk), .rstn(rstn), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack), .ld_valid(ld_valid), .ld_addr(ld_addr), .ld_data(ld_data),
        .pkt_start(pkt_start), .pkt_end(pkt_end), .arb_next(arb_next), .arb_req(arb_req),
        .arb_credit_ok(arb_credit_ok), .arb_grant(arb_grant),
        .arb_grant_valid(arb_grant_valid), .cred_tick(cred_tick), .cred_pend(cred_pend),
        .cred_release(cred_release), .replay_timeout(replay_timeout),
        .ack_latency(ack_latency), .store_forward(store_forward),
        .ct_ahead_cycles(ct_ahead_cycles), .vga_decode_en(vga_decode_en));
    sltc_pkt_src #(.LEN(8)) u_src (.sys_clk(sys_clk), .rstn(rstn), .go(go),
        .pkt_start(pkt_start), .pkt_end(pkt_end));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // one access; the ack rises at the same edge that takes the request
    task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] be,
            input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        {cfg_req, cfg_wr, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, w, a, be, d};
        @(posedge sys_clk);
        cfg_req <= 1'b0;
        #1;
        for (n = 0; n < 4 && cfg_ack !== 1'b1; n++) tick(1);
        if (n == 4) begin
            fails++;
            end_sim();
        end
        r = cfg_rdata;
    endtask
    task automatic pkt_go();
        @(posedge sys_clk);
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
    endtask
    task automatic arb(input logic [3:0] rq, input logic [3:0] ok, input logic [31:0] exp);
        @(posedge sys_clk);
        {arb_req, arb_credit_ok, arb_next} <= {rq, ok, 1'b1};
        @(posedge sys_clk);
        arb_next <= 1'b0;
        #1;
        chk({arb_grant_valid, arb_grant}, exp);
    endtask
    task automatic cred(input logic [2:0] pend, input logic [31:0] exp);
        @(posedge sys_clk);
        {cred_pend, cred_tick} <= {pend, 1'b1};
        @(posedge sys_clk);
        cred_tick <= 1'b0;
        #1;
        chk(32'(cred_release), exp);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic s_reset();
        cfg(0, SLTC_TIMER_CTRL_OFS, 4'hf, 0);
        chk(r, 32'h8000_0000);
        cfg(0, SLTC_TEST_SCRATCH_OFS, 4'hf, 0);
        chk(r, SLTC_TEST_SCRATCH_RST);
        cfg(0, SLTC_FWD_POLICY_OFS, 4'hf, 0);
        chk(r, 32'h2);
        cfg(0, 8'h78, 4'hf, 0);
        chk(r, 32'h0);
        chk({replay_timeout, ack_latency}, {RDEF, ADEF});
        chk(32'(vga_decode_en), 32'h1);
    endtask
    task automatic s_timer();
        cfg(1, SLTC_TIMER_CTRL_OFS, 4'hf, 32'hffff_ffff);
        cfg(0, SLTC_TIMER_CTRL_OFS, 4'hf, 0);
        chk(r, 32'hffff_1fff);
        chk({replay_timeout, ack_latency}, {12'hfff, 14'h3fff});
        cfg(1, SLTC_TIMER_CTRL_OFS, 4'hf, 32'h0123_0abc);
        cfg(1, SLTC_TIMER_CTRL_OFS, 4'h1, 32'h0000_0055);
        cfg(0, SLTC_TIMER_CTRL_OFS, 4'hf, 0);
        chk(r, 32'h8123_0a55);
        chk({replay_timeout, ack_latency}, {RDEF, ADEF});
    endtask
    // load replaces the word, but the path only sees it at the next packet
    task automatic s_load_fwd();
        @(posedge sys_clk);
        {ld_valid, ld_addr, ld_data} <= {1'b1, SLTC_FWD_POLICY_OFS, 32'h7};
        @(posedge sys_clk);
        ld_valid <= 1'b0;
        cfg(0, SLTC_FWD_POLICY_OFS, 4'hf, 0);
        chk(r & 32'h1f, 32'h7);
        chk({ct_ahead_cycles, store_forward}, 32'h2);
        pkt_go();
        tick(10);
        prev = 32'h7;
        for (int c = 0; c < 4; c++) begin
            pkt_go();
            cfg(1, SLTC_FWD_POLICY_OFS, 4'hf, 32'(c * 2 + c % 2));
            chk({ct_ahead_cycles, store_forward}, prev);
            tick(10);
            pkt_go();
            tick(3);
            prev = 32'(c * 2 + c % 2);
            chk({ct_ahead_cycles, store_forward}, prev);
            tick(10);
        end
    endtask
    task automatic s_arb_cred();
        cfg(1, SLTC_FWD_POLICY_OFS, 4'hf, 32'h0);
        pkt_go();
        tick(10);
        arb(4'b0110, 4'b0100, 32'h6);
        arb(4'b0110, 4'b0010, 32'h5);
        cfg(1, SLTC_FWD_POLICY_OFS, 4'hf, 32'h8);
        pkt_go();
        tick(10);
        arb(4'b0110, 4'b0000, 32'h5);
        arb(4'b0000, 4'b1111, 32'h1);
        cred(3'b111, 32'h1);
        cred(3'b111, 32'h2);
        cred(3'b111, 32'h4);
        cred(3'b110, 32'h0);
        cfg(1, SLTC_FWD_POLICY_OFS, 4'hf, 32'h10);
        cred(3'b110, 32'h6);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        rstn = 1'b0;
        {cfg_req, cfg_wr, cfg_addr, cfg_be, cfg_wdata, ld_valid, ld_addr, ld_data} = '0;
        {arb_next, arb_req, arb_credit_ok, cred_tick, cred_pend, go} = '0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        s_reset();
        s_timer();
        s_load_fwd();
        s_arb_cred();
        end_sim();
    end
endmodule
bind sltc_config sltc_config_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .pkt_start(pkt_start), .arb_next(arb_next), .arb_req(arb_req),
    .arb_grant(arb_grant), .arb_grant_valid(arb_grant_valid), .cred_tick(cred_tick),
    .cred_pend(cred_pend), .cred_release(cred_release), .store_forward(store_forward),
    .ct_ahead_cycles(ct_ahead_cycles), .vga_decode_en(vga_decode_en));
